// file: rtl/astx_top.sv
// module: async frame transmitter with baud divider and ahb-lite registers
`timescale 1ns/1ps
module astx_top
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire astx_pkg::astx_ahb_req_s ahb_in,
    output astx_pkg::astx_ahb_rsp_s ahb_out,
    input wire logic rx_line_in,
    output logic tx_line_out
);
    import astx_pkg::*;

    function automatic logic [4:0] data_bits(input logic [3:0] code);
        data_bits = ((code >= WIDTH_MIN) && (code <= WIDTH_MAX)) ? 5'(code) + WIDTH_OFS
                                                                 : 5'(WIDTH_RST) + WIDTH_OFS;
    endfunction : data_bits

    function automatic logic [5:0] ovs_ticks(input logic [1:0] code);
        case (code)
            OVS_C16: ovs_ticks = OVS_X16;
            OVS_C8: ovs_ticks = OVS_X8;
            OVS_C6: ovs_ticks = OVS_X6;
            default: ovs_ticks = OVS_X4;
        endcase
    endfunction : ovs_ticks

    // registers
    logic sync_r, high_bit_first_select_r, transmit_polarity_flip_r, receive_polarity_flip_r, on_r, flag_txc_r, flag_ovf_r, txc_q_r;
    logic [1:0] ovs_r, par_r, stop_r, cnt_r;
    logic [3:0] width_r;
    logic [DIV_W-1:0] div_r;
    logic [DATA_W-1:0] buf_mem_r [BUF_DEPTH];
    logic wr_idx_r, rd_idx_r;
    logic rx_s1_r, rx_s2_r;
    astx_state_e state_r, state_nxt;
    logic [13:0] bcnt_r;
    logic [1:0] grp_r;
    logic [5:0] sub_r;
    logic [4:0] bit_idx_r;
    logic [DATA_W-1:0] dat_r;
    logic line_r;

    // bus slave: address phase capture, zero wait states
    logic dp_wr_r;
    logic [7:0] dp_addr_r;
    logic [31:0] hrdata_r, rd_mux;
    wire logic addr_ok = ahb_in.hsel & ahb_in.htrans[HTRANS_ACT] & ahb_in.hready;
    wire logic [31:0] wdata = ahb_in.hwdata;

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            dp_wr_r <= 1'b0;
            dp_addr_r <= 8'h00;
            hrdata_r <= 32'h0000_0000;
        end
        else
        begin
            dp_wr_r <= addr_ok & ahb_in.hwrite;
            dp_addr_r <= addr_ok ? ahb_in.haddr[7:0] : dp_addr_r;
            hrdata_r <= (addr_ok & ~ahb_in.hwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    assign ahb_out.hreadyout = 1'b1;
    assign ahb_out.hresp = 1'b0;
    assign ahb_out.hrdata = hrdata_r;

    wire logic wr_ctrl = dp_wr_r && (dp_addr_r == ADDR_CTRL);
    wire logic wr_frame = dp_wr_r && (dp_addr_r == ADDR_FRAME);
    wire logic wr_div = dp_wr_r && (dp_addr_r == ADDR_DIV);
    wire logic wr_cmd = dp_wr_r && (dp_addr_r == ADDR_CMD);
    wire logic wr_clr = dp_wr_r && (dp_addr_r == ADDR_FLAG_CLR);
    wire logic wr_data = dp_wr_r && (dp_addr_r == ADDR_TXDATA);
    wire logic cmd_on = wr_cmd & wdata[CMD_ON];
    wire logic cmd_off = wr_cmd & wdata[CMD_OFF];
    wire logic on_nxt = cmd_off ? 1'b0 : (cmd_on | on_r);

    // buffer and frame control
    wire logic [4:0] nbits = data_bits(width_r);
    wire logic [5:0] oversample_select = ovs_ticks(ovs_r);
    wire logic [5:0] half = {1'b0, oversample_select[5:1]};
    wire logic has_par = (par_r == PAR_EVEN) || (par_r == PAR_ODD);
    wire logic buf_full = (cnt_r == 2'(BUF_DEPTH));
    wire logic buf_empty = (cnt_r == 2'h0);
    wire logic push = wr_data & ~buf_full;
    wire logic ovf_evt = wr_data & buf_full;
    wire logic txc_cond = on_r & buf_empty & (state_r == S_IDLE);
    wire logic tick = (bcnt_r == 14'h0);
    logic [5:0] span;
    wire logic bit_end = tick && (sub_r == span - 6'h01);
    wire logic free_slot = (state_r == S_IDLE) || ((state_r == S_STOP) && bit_end);
    wire logic load_go = on_r & ~cmd_off & ~sync_r & ~buf_empty & free_slot;
    wire logic last_data = bit_idx_r == (nbits - 5'h01);

    always_comb
    begin
        case (stop_r)
            STOP_HALF: span = half;
            STOP_ONE: span = oversample_select;
            STOP_ONE_HALF: span = oversample_select + half;
            default: span = {oversample_select[4:0], 1'b0};
        endcase
        if (state_r != S_STOP)
            span = oversample_select;
    end

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            sync_r <= 1'b0;
            high_bit_first_select_r <= 1'b0;
            transmit_polarity_flip_r <= 1'b0;
            receive_polarity_flip_r <= 1'b0;
            ovs_r <= OVS_C16;
            width_r <= WIDTH_RST;
            par_r <= PAR_NONE;
            stop_r <= STOP_RST;
            div_r <= '0;
            on_r <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
            begin
                sync_r <= wdata[CTRL_SYNC];
                high_bit_first_select_r <= wdata[CTRL_HIGH_BIT_FIRST_SELECT];
                transmit_polarity_flip_r <= wdata[CTRL_TRANSMIT_POLARITY_FLIP];
                receive_polarity_flip_r <= wdata[CTRL_RECEIVE_POLARITY_FLIP];
                ovs_r <= wdata[CTRL_OVS +: 2];
            end
            if (wr_frame)
            begin
                width_r <= wdata[FRM_WIDTH +: 4];
                par_r <= wdata[FRM_PAR +: 2];
                stop_r <= wdata[FRM_STOP +: 2];
            end
            if (wr_div)
                div_r <= wdata[DIV_W-1:0];
            on_r <= on_nxt;
        end
    end

    // flags: hardware set wins over software clear
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            flag_txc_r <= 1'b0;
            flag_ovf_r <= 1'b0;
            txc_q_r <= 1'b0;
        end
        else
        begin
            txc_q_r <= txc_cond;
            flag_txc_r <= (txc_cond & ~txc_q_r) | (flag_txc_r & ~(wr_clr & wdata[FL_TXC]));
            flag_ovf_r <= ovf_evt | (flag_ovf_r & ~(wr_clr & wdata[FL_OVF]));
        end
    end

    // two-entry transmit buffer
    for (genvar i = 0; i < BUF_DEPTH; i++)
    begin : g_buf
        always_ff @(posedge clk_in or negedge rst_b_in)
        begin
            if (!rst_b_in)
                buf_mem_r[i] <= '0;
            else if (push && (wr_idx_r == 1'(i)))
                buf_mem_r[i] <= wdata[DATA_W-1:0];
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            wr_idx_r <= 1'b0;
            rd_idx_r <= 1'b0;
            cnt_r <= 2'h0;
        end
        else
        begin
            wr_idx_r <= wr_idx_r ^ push;
            rd_idx_r <= rd_idx_r ^ load_go;
            cnt_r <= cnt_r + 2'(push) - 2'(load_go);
        end
    end

    // baud tick: reload integer part, one extra cycle on fraction periods
    wire logic [13:0] div_int = {1'b0, div_r[DIV_W-1:FRAC_W]};
    wire logic [FRAC_W-1:0] grp_now = load_go ? 2'h0 : grp_r;
    wire logic extend = grp_now < div_r[FRAC_W-1:0];
    wire logic [13:0] reload = div_int + 14'(extend);

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            bcnt_r <= 14'h0;
            grp_r <= 2'h0;
        end
        else
        begin
            bcnt_r <= (tick | load_go) ? reload : bcnt_r - 14'h1;
            grp_r <= load_go ? 2'h1 : grp_r + 2'(tick);
        end
    end

    // frame sequencer
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            S_IDLE: if (load_go) state_nxt = S_START;
            S_START: if (bit_end) state_nxt = S_DATA;
            S_DATA: if (bit_end && last_data) state_nxt = has_par ? S_PAR : S_STOP;
            S_PAR: if (bit_end) state_nxt = S_STOP;
            S_STOP: if (bit_end) state_nxt = load_go ? S_START : S_IDLE;
            default: state_nxt = S_IDLE;
        endcase
        if (!on_nxt)
            state_nxt = S_IDLE;
    end

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            state_r <= S_IDLE;
            sub_r <= 6'h0;
            bit_idx_r <= 5'h0;
            dat_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
            sub_r <= (load_go | bit_end) ? 6'h0 : sub_r + 6'(tick);
            bit_idx_r <= load_go ? 5'h0 : bit_idx_r + 5'((state_r == S_DATA) & bit_end);
            dat_r <= load_go ? buf_mem_r[rd_idx_r] : dat_r;
        end
    end

    // line level
    wire logic [4:0] pos = high_bit_first_select_r ? (nbits - 5'h01 - bit_idx_r) : bit_idx_r;
    wire logic [DATA_W-1:0] mask = DATA_W'((17'h1 << nbits) - 17'h1);
    wire logic par_bit = (^(dat_r & mask)) ^ (par_r == PAR_ODD);
    logic bit_val;

    always_comb
    begin
        case (state_r)
            S_START: bit_val = 1'b0;
            S_DATA: bit_val = dat_r[pos[3:0]];
            S_PAR: bit_val = par_bit;
            default: bit_val = 1'b1;
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            line_r <= 1'b1;
            rx_s1_r <= 1'b1;
            rx_s2_r <= 1'b1;
        end
        else
        begin
            line_r <= bit_val ^ transmit_polarity_flip_r;
            rx_s1_r <= rx_line_in;
            rx_s2_r <= rx_s1_r;
        end
    end

    assign tx_line_out = line_r;

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        case (ahb_in.haddr[7:0])
            ADDR_CTRL: rd_mux = 32'({ovs_r, receive_polarity_flip_r, transmit_polarity_flip_r, high_bit_first_select_r, sync_r});
            ADDR_FRAME: rd_mux = 32'({stop_r, 2'h0, par_r, 4'h0, width_r});
            ADDR_DIV: rd_mux = 32'(div_r);
            ADDR_STATUS: rd_mux = 32'({cnt_r, 1'b0, rx_s2_r ^ receive_polarity_flip_r, txc_cond, on_r});
            ADDR_FLAGS: rd_mux = 32'({flag_ovf_r, flag_txc_r});
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // checks
    logic [13:0] gap_r, rl_q_r;
    wire logic sts_rd = addr_ok & (ahb_in.haddr[7:0] == ADDR_STATUS);
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            gap_r <= 14'h1;
            rl_q_r <= 14'h0;
        end
        else
        begin
            gap_r <= (tick | load_go) ? 14'h1 : gap_r + 14'h1;
            rl_q_r <= (tick | load_go) ? reload : rl_q_r;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    start_level_a: assert property ((state_r == S_START) |=> (tx_line_out == $past(transmit_polarity_flip_r)))
        else $error("start bit level wrong");
    stop_level_a: assert property ((state_r == S_STOP) |=> (tx_line_out == !$past(transmit_polarity_flip_r)))
        else $error("stop bit level wrong");
    idle_off_a: assert property (!on_r |-> (state_r == S_IDLE) ##1 (tx_line_out == !$past(transmit_polarity_flip_r)))
        else $error("disabled line not idle");
    off_abort_a: assert property (cmd_off |=> (!on_r && state_r == S_IDLE))
        else $error("off command did not abort");
    overflow_a: assert property (ovf_evt |=> (flag_ovf_r && cnt_r == $past(cnt_r) - 2'($past(load_go))))
        else $error("overflow not flagged or data taken");
    txc_clear_a: assert property ((sts_rd && !buf_empty) |=> !ahb_out.hrdata[STS_TXC])
        else $error("complete status with frame waiting");
    tick_gap_a: assert property ((tick && !$past(load_go)) |-> (gap_r == rl_q_r + 14'h1))
        else $error("baud period wrong");
    parity_bit_a: assert property ((state_r == S_PAR) |=> (tx_line_out ^ $past(transmit_polarity_flip_r)) == $past(par_bit))
        else $error("parity bit wrong");
    load_next_a: assert property (load_go |=> (state_r == S_START && sub_r == 6'h0))
        else $error("frame not started on load");
    bit_len_a: assert property ((state_r == S_START && bit_end) |-> (sub_r == oversample_select - 6'h01))
        else $error("start bit length wrong");

    frame_done_c: cover property ((state_r == S_STOP) && bit_end && !load_go);
    back_to_back_c: cover property ((state_r == S_STOP) && load_go);
    overflow_c: cover property (ovf_evt);
    abort_c: cover property (cmd_off && (state_r == S_DATA));
endmodule : astx_top

// file: shared/astx_pkg.sv
// package: register map, field layout and types of the async frame transmitter
package astx_pkg;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_FRAME = 8'h04;
    localparam logic [7:0] ADDR_DIV = 8'h08;
    localparam logic [7:0] ADDR_CMD = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_FLAGS = 8'h14;
    localparam logic [7:0] ADDR_FLAG_CLR = 8'h18;
    localparam logic [7:0] ADDR_TXDATA = 8'h1C;
    localparam int CTRL_SYNC = 0;
    localparam int CTRL_HIGH_BIT_FIRST_SELECT = 1;
    localparam int CTRL_TRANSMIT_POLARITY_FLIP = 2;
    localparam int CTRL_RECEIVE_POLARITY_FLIP = 3;
    localparam int CTRL_OVS = 4;
    localparam int FRM_WIDTH = 0;
    localparam int FRM_PAR = 8;
    localparam int FRM_STOP = 12;
    localparam int CMD_ON = 0;
    localparam int CMD_OFF = 1;
    localparam int STS_ON = 0;
    localparam int STS_TXC = 1;
    localparam int STS_RXL = 2;
    localparam int STS_LVL = 4;
    localparam int FL_TXC = 0;
    localparam int FL_OVF = 1;
    localparam int HTRANS_ACT = 1;
    localparam int DIV_W = 15;
    localparam int FRAC_W = 2;
    localparam int DATA_W = 16;
    localparam int BUF_DEPTH = 2;
    localparam logic [3:0] WIDTH_RST = 4'h5;
    localparam logic [3:0] WIDTH_MIN = 4'h1;
    localparam logic [3:0] WIDTH_MAX = 4'hD;
    localparam logic [4:0] WIDTH_OFS = 5'h03;
    localparam logic [1:0] STOP_RST = 2'h1;
    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_EVEN = 2'h2;
    localparam logic [1:0] PAR_ODD = 2'h3;
    localparam logic [1:0] STOP_HALF = 2'h0;
    localparam logic [1:0] STOP_ONE = 2'h1;
    localparam logic [1:0] STOP_ONE_HALF = 2'h2;
    localparam logic [1:0] OVS_C16 = 2'h0;
    localparam logic [1:0] OVS_C8 = 2'h1;
    localparam logic [1:0] OVS_C6 = 2'h2;
    localparam logic [5:0] OVS_X16 = 6'h10;
    localparam logic [5:0] OVS_X8 = 6'h08;
    localparam logic [5:0] OVS_X6 = 6'h06;
    localparam logic [5:0] OVS_X4 = 6'h04;

    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_START = 5'h02,
        S_DATA = 5'h04,
        S_PAR = 5'h08,
        S_STOP = 5'h10
    } astx_state_e;

    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic hready;
        logic [31:0] hwdata;
    } astx_ahb_req_s;

    typedef struct packed {
        logic hreadyout;
        logic hresp;
        logic [31:0] hrdata;
    } astx_ahb_rsp_s;
endpackage : astx_pkg

// file: tb/astx_remote_node.sv
// remote serial node model: decodes frames seen on the transmit line
`timescale 1ns/1ps
module astx_remote_node
(
    input wire logic clk_in,
    input wire logic line_in,
    input wire logic en_in,
    input wire logic inv_in,
    input wire logic par_en_in,
    input wire logic [31:0] bit_clks_in,
    input wire logic [31:0] nbits_in,
    output logic rx_line_out,
    output logic [15:0] data_out,
    output logic par_out,
    output logic stop_ok_out,
    output int frames_out,
    output int gap_out
);
    int cyc = 0;
    int last = 0;
    logic lvl;
    assign rx_line_out = 1'b1;
    assign lvl = line_in ^ inv_in;
    always @(posedge clk_in) cyc <= cyc + 1;
    initial
    begin
        frames_out = 0;
        gap_out = 0;
        forever
        begin
            @(posedge clk_in);
            if (en_in && lvl === 1'b0)
            begin
                gap_out = cyc - last;
                last = cyc;
                data_out = '0;
                par_out = 1'b0;
                repeat (bit_clks_in / 2) @(posedge clk_in);
                for (int i = 0; i < nbits_in; i++)
                begin
                    repeat (bit_clks_in) @(posedge clk_in);
                    data_out[i] = lvl;
                end
                if (par_en_in)
                begin
                    repeat (bit_clks_in) @(posedge clk_in);
                    par_out = lvl;
                end
                repeat (bit_clks_in - bit_clks_in / 4) @(posedge clk_in);
                stop_ok_out = (lvl === 1'b1);
                frames_out++;
            end
        end
    end
endmodule : astx_remote_node

// file: tb/astx_top_tb.sv
// testbench of the async frame transmitter
`timescale 1ns/1ps
module astx_top_tb;
    import astx_pkg::*;
    typedef struct {
        logic [31:0] ctrl;
        logic [31:0] frm;
        logic [31:0] div;
        logic [15:0] data;
        logic [15:0] exp;
        logic expp;
        int bc;
        int nb;
        int gap;
    } astx_row_s;
    logic clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    astx_ahb_req_s req;
    astx_ahb_rsp_s rsp;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic tx_line;
    logic rx_line;
    logic en = 1'b0;
    logic inv = 1'b0;
    logic par_en = 1'b0;
    int bc = 4;
    int nb = 4;
    logic [15:0] rx_data;
    logic rx_par;
    logic stop_ok;
    int frames;
    int gap;
    int miscompares = 0;
    int num_checks = 0;
    int cycles = 0;
    int n0;
    logic bad;
    logic [31:0] rd;
    astx_row_s rows [8] = '{
        '{32'h32, 32'h0205, 32'h0, 16'h00B1, 16'h008D, 1'b0, 4, 8, 42},
        '{32'h24, 32'h230D, 32'h0, 16'hF00F, 16'hF00F, 1'b1, 6, 16, 117},
        '{32'h10, 32'h3302, 32'h0, 16'h0015, 16'h0015, 1'b0, 8, 5, 72},
        '{32'h06, 32'h1204, 32'h0, 16'h0046, 16'h0031, 1'b1, 16, 7, 160},
        '{32'h30, 32'h1001, 32'h1, 16'h0005, 16'h0005, 1'b0, 5, 4, 30},
        '{32'h30, 32'h1001, 32'h3, 16'h0006, 16'h0006, 1'b0, 7, 4, 42},
        '{32'h30, 32'h1001, 32'h4, 16'h0009, 16'h0009, 1'b0, 8, 4, 48},
        '{32'h30, 32'h1101, 32'h0, 16'h0003, 16'h0003, 1'b0, 4, 4, 24}
    };

    assign req = '{hsel, haddr, htrans, hwrite, 3'h2, rsp.hreadyout, hwdata};

    astx_top dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .ahb_in(req), .ahb_out(rsp),
        .rx_line_in(rx_line), .tx_line_out(tx_line));
    astx_remote_node peer (.clk_in(clk_in), .line_in(tx_line), .en_in(en), .inv_in(inv),
        .par_en_in(par_en), .bit_clks_in(bc), .nbits_in(nb), .rx_line_out(rx_line),
        .data_out(rx_data), .par_out(rx_par), .stop_ok_out(stop_ok), .frames_out(frames),
        .gap_out(gap));

    initial
    begin
        forever #2 clk_in = ~clk_in;
    end

    task tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish

    always @(posedge clk_in)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            miscompares++;
            tally_and_finish();
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one single ahb-lite transfer: address phase, then data phase
    task xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
        @(posedge clk_in);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk_in); while (rsp.hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_in); while (rsp.hreadyout !== 1'b1);
        rd = rsp.hrdata;
    endtask : xfer

    task rdchk(input logic [7:0] a, input logic [31:0] e);
        xfer(a, 1'b0, 32'h0);
        chk(rd, e);
    endtask : rdchk

    task watch_idle(input int n);
        bad = 1'b0;
        repeat (2) @(posedge clk_in);
        repeat (n)
        begin
            @(posedge clk_in);
            bad |= (tx_line !== 1'b1);
        end
    endtask : watch_idle

    // two frames back to back, checked at the remote node
    task run_cfg(input astx_row_s r);
        en = 1'b0;
        xfer(ADDR_CTRL, 1'b1, r.ctrl);
        xfer(ADDR_FRAME, 1'b1, r.frm);
        xfer(ADDR_DIV, 1'b1, r.div);
        inv = r.ctrl[CTRL_TRANSMIT_POLARITY_FLIP];
        par_en = r.frm[FRM_PAR + 1];
        bc = r.bc;
        nb = r.nb;
        repeat (3) @(posedge clk_in);
        en = 1'b1;
        n0 = frames;
        xfer(ADDR_TXDATA, 1'b1, {16'h0, r.data});
        xfer(ADDR_TXDATA, 1'b1, {16'h0, r.data});
        while (frames < n0 + 2) @(posedge clk_in);
        chk(rx_data, r.exp);
        chk(rx_par, r.expp);
        chk(stop_ok, 1);
        chk(gap, r.gap);
        $display("test frame config %h %h %h done", r.ctrl, r.frm, r.div);
    endtask : run_cfg

    initial
    begin
        repeat (2) @(posedge clk_in);
        chk(tx_line, 1);
        rst_b_in <= 1'b1;
        rdchk(ADDR_CTRL, 32'h0);
        rdchk(ADDR_FRAME, 32'h1005);
        rdchk(ADDR_STATUS, 32'h4);
        rdchk(8'h20, 32'h0);
        $display("test reset done");
        xfer(ADDR_CTRL, 1'b1, 32'h30);
        xfer(ADDR_FRAME, 1'b1, 32'h1001);
        for (int i = 1; i <= 3; i++)
            xfer(ADDR_TXDATA, 1'b1, i);
        rdchk(ADDR_FLAGS, 32'h2);
        rdchk(ADDR_STATUS, 32'h24);
        chk(tx_line, 1);
        xfer(ADDR_FLAG_CLR, 1'b1, 32'h3);
        rdchk(ADDR_FLAGS, 32'h0);
        n0 = frames;
        en = 1'b1;
        xfer(ADDR_CMD, 1'b1, 32'h1);
        repeat (200) @(posedge clk_in);
        chk(frames - n0, 2);
        chk(rx_data, 16'h0002);
        rdchk(ADDR_STATUS, 32'h7);
        rdchk(ADDR_FLAGS, 32'h1);
        xfer(ADDR_FLAG_CLR, 1'b1, 32'h1);
        rdchk(ADDR_FLAGS, 32'h0);
        $display("test buffer and flags done");
        foreach (rows[k])
            run_cfg(rows[k]);
        for (int c = 1; c <= 13; c++)
            run_cfg(astx_row_s'{32'h30, 32'h1000 | c, 32'h0, 16'hA5C3,
                16'hA5C3 & ((17'h1 << (c + 3)) - 17'h1), 1'b0, 4, c + 3, 4 * c + 20});
        run_cfg(astx_row_s'{32'h30, 32'h1000, 32'h0, 16'h01A5, 16'h00A5, 1'b0, 4, 8, 40});
        en = 1'b0;
        xfer(ADDR_CTRL, 1'b1, 32'h0);
        xfer(ADDR_FRAME, 1'b1, 32'h1005);
        xfer(ADDR_TXDATA, 1'b1, 32'h0);
        xfer(ADDR_STATUS, 1'b0, 32'h0);
        chk(rd & 32'h3, 32'h1);
        repeat (20) @(posedge clk_in);
        chk(tx_line, 0);
        xfer(ADDR_CMD, 1'b1, 32'h2);
        watch_idle(300);
        chk(bad, 0);
        rdchk(ADDR_STATUS, 32'h4);
        $display("test abort done");
        xfer(ADDR_CTRL, 1'b1, 32'h31);
        xfer(ADDR_CMD, 1'b1, 32'h1);
        xfer(ADDR_TXDATA, 1'b1, 32'h0);
        watch_idle(100);
        chk(bad, 0);
        xfer(ADDR_CTRL, 1'b1, 32'h39);
        rdchk(ADDR_STATUS, 32'h11);
        $display("test sync select done");
        tally_and_finish();
    end
endmodule : astx_top_tb
